// *** dvc_ctrl.sv ***
// detect-and-vacate controller: channel selection, virtual detects, guidance tag
// assumes all inputs synchronous to SYS_CLK_I; radio accepts tune commands any time
// Rules this block is written to
// [R1] reset selects primary channel 173
// [R2] detection retunes radio to backup 48
// [R3] detector raises detect about 10 us
// [R4] sample detect except during tx/rx
// [R5] any detection starts immediate retune
// [R6] report each detection to upper MAC
// [R7] suspend transmission before and during retune
// [R8] wait 100 us then resume
// [R9] physical detect comes from external pin
// [R10] virtual detect treated like physical
// [R11] client inactivity timer restarts per AP frame
// [R12] inactivity threshold 335 ms raises detect; code takes the threshold from INACT_LIMIT_I, INACT_CYC is unused
// [R13] max consecutive unacked retries raises detect
// [R14] AP inserts tag in beacons, assoc responses
// [R15] client stores tag channel as backup
// [R16] once vacated ignore detections until reset
`timescale 1ns/1ps
`default_nettype none
`include "dvc_defines.svh"
module dvc_ctrl #(
  parameter int INACT_CYC = `DVC_INACT_CYC,
  parameter int RETUNE_CYC = `DVC_RETUNE_CYC
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              PREAMBLE_DETECT_FLAG_I,
  input  wire logic              TX_ACTIVE_I,
  input  wire logic              RX_ACTIVE_I,
  input  wire logic              ROLE_AP_I,
  input  wire logic              AP_FRAME_RX_I,
  input  wire logic              TX_ACKED_I,
  input  wire logic              TX_FAILED_I,
  input  wire logic [7:0]        MAX_RETRY_I,
  input  wire logic [31:0]       INACT_LIMIT_I,
  input  wire dvc_pkg::dvc_tag_t RX_ASSOC_TAG_I,
  input  wire logic              TX_MGMT_I,
  output dvc_pkg::dvc_tune_t     TUNE_O,
  output dvc_pkg::dvc_tag_t      TX_TAG_O,
  output logic                   TX_SUSPEND_O,
  output logic                   DETECT_EVENT_O,
  output logic                   VIRTUAL_DETECT_O,
  output logic [7:0]             CHANNEL_O,
  output logic                   VACATED_O
);
  import dvc_pkg::*;

  // ==========================================================
  // detection sources
  dvc_state_t  state_r, state_nxt;
  logic [31:0] rt_cnt_r;
  logic [7:0]  retry_r;
  logic [7:0]  backup_r;
  logic        inact_hit;
  logic        sample_ok;
  logic        phys_det;
  logic        retry_hit;
  logic        virt_det;
  logic        detect;
  logic        retune_done;

  assign sample_ok = !TX_ACTIVE_I && !RX_ACTIVE_I;                    // [R4]
  assign phys_det  = PREAMBLE_DETECT_FLAG_I && sample_ok;             // [R9]
  assign retry_hit = TX_FAILED_I && (retry_r + 8'h01 >= MAX_RETRY_I); // [R13]
  assign virt_det  = (inact_hit && !ROLE_AP_I) || retry_hit;          // [R10]
  assign detect    = (phys_det || virt_det) && state_r == DVC_ON_PRIMARY; // [R5] [R16]
  assign retune_done = rt_cnt_r == 32'(RETUNE_CYC - 1);               // [R8]

  dvc_timer #(.W(32)) u_inact (
    .SYS_CLK_I (SYS_CLK_I),
    .SRST_I    (SRST_I),
    .RESTART_I (AP_FRAME_RX_I),                                       // [R11]
    .RUN_I     (!ROLE_AP_I && state_r == DVC_ON_PRIMARY),
    .LIMIT_I   (INACT_LIMIT_I),                                       // [R12]
    .HIT_O     (inact_hit)
  );

  // ==========================================================
  // vacate state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DVC_ON_PRIMARY: if (detect) state_nxt = DVC_RETUNING;
      DVC_RETUNING:   if (retune_done) state_nxt = DVC_ON_BACKUP;
      DVC_ON_BACKUP:  state_nxt = DVC_ON_BACKUP;                      // [R16]
      default:        state_nxt = DVC_ON_PRIMARY;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      state_r  <= DVC_ON_PRIMARY;                                     // [R1]
      rt_cnt_r <= '0;
      retry_r  <= '0;
      backup_r <= `DVC_BACKUP_CH_DFLT;                                // [R2]
    end else begin
      state_r  <= state_nxt;
      rt_cnt_r <= (state_r == DVC_RETUNING) ? rt_cnt_r + 32'h1 : '0;
      if (TX_ACKED_I)
        retry_r <= '0;
      else if (TX_FAILED_I)
        retry_r <= retry_r + 8'h01;
      if (!ROLE_AP_I && RX_ASSOC_TAG_I.valid && state_r == DVC_ON_PRIMARY)
        backup_r <= RX_ASSOC_TAG_I.channel;                           // [R15]
    end
  end

  // ==========================================================
  // outputs
  dvc_tune_t tune_r;
  dvc_tag_t  tag_r;
  logic      evt_r, virt_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      tune_r <= '{valid: 1'b1, channel: `DVC_PRIMARY_CH};             // [R1]
      tag_r  <= '0;
      evt_r  <= 1'b0;
      virt_r <= 1'b0;
    end else begin
      tune_r.valid   <= detect;                                       // [R5]
      if (detect)
        tune_r.channel <= backup_r;                                   // [R2]
      tag_r.valid    <= ROLE_AP_I && TX_MGMT_I;                       // [R14]
      tag_r.channel  <= backup_r;
      evt_r  <= detect;                                               // [R6]
      virt_r <= detect && !phys_det;
    end
  end

  assign TUNE_O           = tune_r;
  assign TX_TAG_O         = tag_r;
  assign TX_SUSPEND_O     = state_r == DVC_RETUNING || detect;        // [R7]
  assign DETECT_EVENT_O   = evt_r;
  assign VIRTUAL_DETECT_O = virt_r;
  assign CHANNEL_O        = tune_r.channel;
  assign VACATED_O        = state_r == DVC_ON_BACKUP;

  // ==========================================================
  // checks
  sequence s_detect;
    detect;
  endsequence
  chk_reset_primary: assert property (@(posedge SYS_CLK_I) $past(SRST_I) |-> CHANNEL_O == `DVC_PRIMARY_CH) // [R1]
    else $error("not on primary after reset");
  chk_retune_backup: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    s_detect |=> TUNE_O.valid && CHANNEL_O == $past(backup_r)) // [R2]
    else $error("retune channel wrong");
  chk_busy_ignore: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (TX_ACTIVE_I || RX_ACTIVE_I) && !virt_det |-> !detect) // [R4]
    else $error("detect sampled during tx or rx");
  chk_report_event: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    s_detect |=> DETECT_EVENT_O) // [R6]
    else $error("detection not reported");
  chk_suspend_hold: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    s_detect |-> TX_SUSPEND_O ##1 TX_SUSPEND_O[*8]) // [R7]
    else $error("tx not suspended during retune");
  chk_retune_wait: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    $rose(VACATED_O) |-> rt_cnt_r == 32'(RETUNE_CYC) && $past(rt_cnt_r) == 32'(RETUNE_CYC - 1)) // [R8]
    else $error("retune wait wrong");
  chk_phys_detect: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    state_r == DVC_ON_PRIMARY && PREAMBLE_DETECT_FLAG_I && sample_ok |=> state_r == DVC_RETUNING) // [R9] [R5]
    else $error("physical detect ignored");
  chk_inact_vacate: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    inact_hit && !ROLE_AP_I && state_r == DVC_ON_PRIMARY |=> VIRTUAL_DETECT_O || DETECT_EVENT_O) // [R10] [R12]
    else $error("inactivity detect lost");
  chk_retry_vacate: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    retry_hit && state_r == DVC_ON_PRIMARY |=> state_r == DVC_RETUNING) // [R13]
    else $error("retry limit detect lost");
  chk_tag_insert: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    ROLE_AP_I && TX_MGMT_I |=> TX_TAG_O.valid && TX_TAG_O.channel == $past(backup_r)) // [R14]
    else $error("guidance tag missing");
  chk_stay_backup: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    VACATED_O |=> VACATED_O && !DETECT_EVENT_O) // [R16]
    else $error("left backup channel");

  // ==========================================================
  // further rule checks
  chk_vacate_resume: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    $rose(VACATED_O) |-> !TX_SUSPEND_O) // [R8]
    else $error("tx still suspended after retune");
  chk_virt_flag: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    detect && !phys_det |=> VIRTUAL_DETECT_O) // [R10]
    else $error("virtual detect not flagged");
  chk_phys_flag: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    detect && phys_det |=> !VIRTUAL_DETECT_O) // [R6]
    else $error("physical detect flagged as virtual");
  chk_tag_learn: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    !ROLE_AP_I && RX_ASSOC_TAG_I.valid && state_r == DVC_ON_PRIMARY |=> backup_r == $past(RX_ASSOC_TAG_I.channel)) // [R15]
    else $error("guidance tag not learned");
  chk_event_pulse: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    DETECT_EVENT_O |=> !DETECT_EVENT_O) // [R6]
    else $error("detect event longer than one cycle");
  chk_primary_hold: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    state_r == DVC_ON_PRIMARY && !detect |=> CHANNEL_O == $past(CHANNEL_O)) // [R1]
    else $error("channel moved without detection");
  chk_inact_restart: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    AP_FRAME_RX_I |=> !inact_hit) // [R11]
    else $error("inactivity timer not restarted");
  chk_suspend_retune: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    state_r == DVC_RETUNING |-> TX_SUSPEND_O) // [R7]
    else $error("tx not suspended while retuning");
  chk_retry_clear: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    TX_ACKED_I |=> retry_r == 8'h00) // [R13]
    else $error("retry count not cleared by ack");
endmodule : dvc_ctrl
`default_nettype wire

// *** dvc_defines.svh ***
// constants for the detect-and-vacate controller
// assumes a 200 MHz system clock
`ifndef DVC_DEFINES_SVH
`define DVC_DEFINES_SVH
`define DVC_CLK_MHZ         200
`define DVC_PRIMARY_CH      8'had
`define DVC_BACKUP_CH_DFLT  8'h30
`define DVC_RETUNE_US       100
`define DVC_RETUNE_CYC      (`DVC_RETUNE_US * `DVC_CLK_MHZ)
`define DVC_INACT_MS        335
`define DVC_INACT_CYC       (`DVC_INACT_MS * 1000 * `DVC_CLK_MHZ)
`define DVC_MAX_RETRY_DFLT  8'h07
`endif

// *** dvc_pkg.sv ***
// types for the detect-and-vacate controller
// assumes dvc_defines.svh is compiled alongside
package dvc_pkg;
  typedef enum logic [1:0] {DVC_ON_PRIMARY, DVC_RETUNING, DVC_ON_BACKUP} dvc_state_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] channel;
  } dvc_tune_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] channel;
  } dvc_tag_t;
endpackage : dvc_pkg

// *** dvc_timer.sv ***
// restartable cycle counter with threshold compare
// assumes a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module dvc_timer #(
  parameter int W = 32
) (
  input  wire logic         SYS_CLK_I,
  input  wire logic         SRST_I,
  input  wire logic         RESTART_I,
  input  wire logic         RUN_I,
  input  wire logic [W-1:0] LIMIT_I,
  output logic              HIT_O
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         hit_r;
  assign cnt_nxt = RESTART_I ? '0 : (RUN_I && cnt_r != LIMIT_I) ? cnt_r + 1'b1 : cnt_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hit_r <= RUN_I && !RESTART_I && (cnt_nxt == LIMIT_I);
    end
  end
  assign HIT_O = hit_r;
endmodule : dvc_timer
`default_nettype wire

// *** dvc_detector.sv ***
// model of the separate preamble detector board
// assumes one system clock; a start pulse marks a preamble on air
`timescale 1ns/1ps
`default_nettype none
module dvc_detector #(
  parameter int DELAY_CYC = 2000
) (
  input  wire logic SYS_CLK_I,
  input  wire logic PREAMBLE_I,
  output logic      PREAMBLE_DETECT_FLAG_O
);
  int cnt_r = -4;
  always @(posedge SYS_CLK_I) begin
    if (PREAMBLE_I) cnt_r <= DELAY_CYC;
    else if (cnt_r > -4) cnt_r <= cnt_r - 1;
  end
  // flag raised about 10 us after each preamble, for four cycles
  assign PREAMBLE_DETECT_FLAG_O = (cnt_r <= 0) && (cnt_r > -4);
endmodule : dvc_detector
`default_nettype wire

// *** test_detect_and_vacate_ctrl.sv ***
// self-checking bench for the detect-and-vacate controller
// assumes dvc_pkg, dvc_ctrl and dvc_detector are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_detect_and_vacate_ctrl;
  import dvc_pkg::*;
  logic clk = 0, rst = 1, tx = 0, rx = 0, ap = 0, apf = 0, ack = 0, fail = 0, mgmt = 0, pre = 0;
  logic [7:0] maxr = 8'h07, tch, ch;
  logic [31:0] lim = 32'hffffffff, lfsr = 32'h8aa1ab97;
  dvc_tag_t tag = '0, txtag;
  dvc_tune_t tune;
  logic pin, susp, det, vdet, vac, lastv;
  int checks = 0, miscompares = 0, cyc = 0, ndet = 0, i;
  dvc_detector dvc_detector_inst (.SYS_CLK_I(clk), .PREAMBLE_I(pre), .PREAMBLE_DETECT_FLAG_O(pin));
  dvc_ctrl #(.RETUNE_CYC(16)) dvc_ctrl_inst (.SYS_CLK_I(clk), .SRST_I(rst), .PREAMBLE_DETECT_FLAG_I(pin),
    .TX_ACTIVE_I(tx), .RX_ACTIVE_I(rx), .ROLE_AP_I(ap), .AP_FRAME_RX_I(apf), .TX_ACKED_I(ack),
    .TX_FAILED_I(fail), .MAX_RETRY_I(maxr), .INACT_LIMIT_I(lim), .RX_ASSOC_TAG_I(tag), .TX_MGMT_I(mgmt),
    .TUNE_O(tune), .TX_TAG_O(txtag), .TX_SUSPEND_O(susp), .DETECT_EVENT_O(det),
    .VIRTUAL_DETECT_O(vdet), .CHANNEL_O(ch), .VACATED_O(vac));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (det) begin
      ndet++;
      lastv = vdet;
    end
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
    step(1);
  endtask : pulse
  task automatic do_reset();
    rst = 1;
    step(6);
    `CHK("reset_channel", 8'had, ch)
    `CHK("reset_tune", 1'b1, tune.valid)
    rst = 0;
    ndet = 0;
  endtask : do_reset
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // physical detection, blocking while busy, then one vacate
  initial begin
    do_reset();
    tx = 1;
    pulse(pre);
    step(2010);
    `CHK("busy_detects", 0, ndet)
    tx = 0;
    pulse(pre);
    for (i = 0; i < 2100 && !det; i++) step(1);
    `CHK("tune_valid", 1'b1, tune.valid)
    `CHK("tune_channel", 8'h30, tune.channel)
    `CHK("channel", 8'h30, ch)
    `CHK("suspend", 1'b1, susp)
    `CHK("phys_virtual", 1'b0, vdet)
    step(15);
    `CHK("retune_busy", 2'b10, {susp, vac})
    step(1);
    `CHK("retune_done", 2'b01, {susp, vac})
    pulse(pre);
    step(2010);
    `CHK("extra_detects", 1, ndet)
    `CHK("still_backup", 8'h30, ch)
    // ==========================================================
    // client: learned backup channel and inactivity timer
    lim = 32'h32;
    do_reset();
    lfsr = nx(lfsr);
    tch = {2'b01, lfsr[5:0]};
    tag = '{1'b1, tch};
    step(1);
    tag = '0;
    repeat (5) begin
      step(39);
      pulse(apf);
    end
    `CHK("inact_early", 0, ndet)
    step(60);
    `CHK("inact_detect", 1, ndet)
    `CHK("inact_virtual", 1'b1, lastv)
    `CHK("learned_ch", tch, ch)
    // ==========================================================
    // access point: guidance tag and retry failures
    do_reset();
    ap = 1;
    mgmt = 1;
    step(1);
    `CHK("ap_tag", 9'h130, txtag)
    mgmt = 0;
    step(1);
    lfsr = nx(lfsr);
    maxr = 8'(lfsr[2:0]) + 8'h02;
    repeat (maxr - 1) pulse(fail);
    pulse(ack);
    repeat (maxr - 1) pulse(fail);
    step(3);
    `CHK("retry_early", 0, ndet)
    pulse(fail);
    step(3);
    `CHK("retry_detect", 1, ndet)
    `CHK("retry_virtual", 1'b1, lastv)
    print_verdict();
  end
endmodule : test_detect_and_vacate_ctrl
`default_nettype wire
